// ===== include/nvm_access_pkg.sv
package nvm_access_pkg;

	// ------------------------------------------------------------
	// Register offsets (byte addresses on the bus).
	// ------------------------------------------------------------
	localparam logic [3:0] CTRL_OFFSET   = 4'h0;  // Control and status register.
	localparam logic [3:0] IRQ_ST_OFFSET = 4'h4;  // Sticky event status.
	localparam logic [3:0] IRQ_MK_OFFSET = 4'h8;  // Event mask.

	// ------------------------------------------------------------
	// Control register field positions.
	// ------------------------------------------------------------
	localparam int PROG_SEL_BIT  = 7;  // Program memory select.
	localparam int CFG_SEL_BIT   = 6;  // Configuration space select.
	localparam int ROW_ERASE_BIT = 4;  // Row erase enable.
	localparam int WR_ERR_BIT    = 3;  // Write error flag.
	localparam int PERMIT_BIT    = 2;  // Write permit.
	localparam int WR_START_BIT  = 1;  // Write start, self clearing.
	localparam int RD_START_BIT  = 0;  // Read start, self clearing.

	// ------------------------------------------------------------
	// Event status field positions and reset values.
	// ------------------------------------------------------------
	localparam int EV_DONE_BIT  = 0;  // A write or erase cycle finished.
	localparam int EV_ERROR_BIT = 1;  // A write start was refused for lack of permit.
	localparam int EV_READ_BIT  = 2;  // A data read was launched.
	localparam int EV_COUNT     = 3;

	localparam logic [7:0]          CTRL_RESET = 8'h00;
	localparam logic [EV_COUNT-1:0] EV_RESET   = 3'h0;

	// ------------------------------------------------------------
	// Memory targets driven towards the array.
	// ------------------------------------------------------------
	localparam logic [1:0] TGT_DATA   = 2'h0;  // Data EEPROM.
	localparam logic [1:0] TGT_PROG   = 2'h1;  // Flash program memory.
	localparam logic [1:0] TGT_CONFIG = 2'h2;  // Configuration registers.

	// One-hot states of the write sequencer.
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_ERASE = 3'b010,
		ST_WRITE = 3'b100
	} wr_state_t;

endpackage

// ===== hdl/nvm_access_control.sv
// What this block does
// - select bits choose config, flash or EEPROM
// - erase enable makes write start erase block
// - erase enable clear gives plain write
// - reset mid-cycle or bad write sets error flag
// - cycles need write permit set
// - write start runs cycle, clears when done
// - read start pulses one read, self clears
// - read start ignored unless EEPROM selected
module nvm_access_control
	import nvm_access_pkg::*;
(
	input  wire logic        core_clk_i,   // Core clock, 25 MHz.
	input  wire logic        srst_i,       // Synchronous reset, active high.
	input  wire logic        ce_i,         // Clock enable; low freezes all state.
	input  wire logic        wb_cyc_i,     // Wishbone cycle.
	input  wire logic        wb_stb_i,     // Wishbone strobe.
	input  wire logic        wb_we_i,      // Wishbone write enable.
	input  wire logic [3:0]  wb_adr_i,     // Wishbone byte address.
	input  wire logic [3:0]  wb_sel_i,     // Wishbone byte selects.
	input  wire logic [31:0] wb_dat_i,     // Wishbone write data.
	output logic      [31:0] wb_dat_o,     // Wishbone read data.
	output logic             wb_ack_o,     // Wishbone acknowledge.
	input  wire logic        nvm_done_i,   // Array finished the timed cycle.
	output logic             nvm_erase_o,  // Erase cycle in progress.
	output logic             nvm_write_o,  // Write cycle in progress.
	output logic             nvm_read_o,   // One-cycle read strobe.
	output logic      [1:0]  nvm_target_o, // Memory addressed by the cycle.
	output logic             irq_o         // Level interrupt.
);

	// ------------------------------------------------------------
	// Storage.
	// ------------------------------------------------------------
	logic                prog_sel_q;   // Program memory select.
	logic                cfg_sel_q;    // Configuration space select.
	logic                erase_en_q;   // Row erase enable.
	logic                err_q;        // Write error flag.
	logic                permit_q;     // Write permit.
	logic                wr_q;         // Write start, visible while busy.
	logic                rd_q;         // Read start, visible one cycle.
	logic                ack_q;        // Bus acknowledge.
	logic [31:0]         rdata_q;      // Registered read data.
	logic [EV_COUNT-1:0] ev_q;         // Sticky event flags.
	logic [EV_COUNT-1:0] mask_q;       // Event mask.
	logic [EV_COUNT-1:0] ev_set;       // Events raised this cycle.
	wr_state_t           st_q;         // Write sequencer state.
	logic                erase_q;      // Erase strobe towards the array.
	logic                write_q;      // Write strobe towards the array.
	logic                read_q;       // Read strobe towards the array.
	logic [1:0]          target_q;     // Latched target.

	// ------------------------------------------------------------
	// Bus decode.
	// ------------------------------------------------------------
	logic       bus_req;      // New request, not yet answered.
	logic       wr_lane0;     // Write touching the low byte.
	logic       ctrl_wr;      // Write to the control register.
	logic [7:0] wbyte;        // Low byte of write data.
	logic       wr_go;        // Accepted write start.
	logic       wr_refused;   // Write start without permit.
	logic       rd_go;        // Accepted read start.
	logic       cycle_end;    // Timed cycle finished.
	logic [7:0] ctrl_view;    // Control register as software sees it.

	// A request counts once: the answered cycle is masked so a held strobe is not seen twice.
	assign bus_req  = wb_cyc_i && wb_stb_i && !ack_q;
	assign wr_lane0 = bus_req && wb_we_i && wb_sel_i[0];
	assign ctrl_wr  = wr_lane0 && (wb_adr_i == CTRL_OFFSET);
	assign wbyte    = wb_dat_i[7:0];

	// A zero written to either start bit falls through; only ones start work.
	assign wr_go      = ctrl_wr && wbyte[WR_START_BIT] && !wr_q && permit_q;
	assign wr_refused = ctrl_wr && wbyte[WR_START_BIT] && !wr_q && !permit_q;
	// Reads are only for data EEPROM, so either select bit blocks them.
	assign rd_go = ctrl_wr && wbyte[RD_START_BIT] && !rd_q && !wr_q
		&& !prog_sel_q && !cfg_sel_q;

	// Completion only matters while a cycle runs; a stray pulse when idle is dropped.
	assign cycle_end = (st_q != ST_IDLE) && nvm_done_i;

	// Bit 5 is unused and always reads as zero.
	assign ctrl_view = {prog_sel_q, cfg_sel_q, 1'b0, erase_en_q,
		err_q, permit_q, wr_q, rd_q};

	// ------------------------------------------------------------
	// Bus answer: one wait state, every address answered.
	// ------------------------------------------------------------
	// Unmapped addresses read as zero and ignore writes, so a stray access never hangs.
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			ack_q   <= 1'b0;
			rdata_q <= 32'h0000_0000;
		end else if (ce_i) begin
			ack_q <= bus_req;
			if (bus_req && !wb_we_i) begin
				unique case (wb_adr_i)
					CTRL_OFFSET:   rdata_q <= {24'h00_0000, ctrl_view};
					IRQ_ST_OFFSET: rdata_q <= {29'h0000_0000, ev_q};
					IRQ_MK_OFFSET: rdata_q <= {29'h0000_0000, mask_q};
					default:       rdata_q <= 32'h0000_0000;
				endcase
			end
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdata_q;

	// ------------------------------------------------------------
	// Plain control fields.
	// ------------------------------------------------------------
	// Selects change only on software writes; the error path never touches them.
	// Erase enable and permit are ordinary read and write bits.
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			prog_sel_q <= CTRL_RESET[PROG_SEL_BIT];
			cfg_sel_q  <= CTRL_RESET[CFG_SEL_BIT];
			erase_en_q <= CTRL_RESET[ROW_ERASE_BIT];
			permit_q   <= CTRL_RESET[PERMIT_BIT];
		end else if (ce_i && ctrl_wr) begin
			prog_sel_q <= wbyte[PROG_SEL_BIT];
			cfg_sel_q  <= wbyte[CFG_SEL_BIT];
			erase_en_q <= wbyte[ROW_ERASE_BIT];
			permit_q   <= wbyte[PERMIT_BIT];
		end
	end

	// ------------------------------------------------------------
	// Error flag.
	// ------------------------------------------------------------
	// A reset that lands in a running cycle leaves the flag set, so software
	// learns after restart that the array contents may be torn.
	// Since reset never clears it, the flag powers up unknown until software
	// writes the control register once; firmware must do that before trusting it.
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			err_q <= err_q || (st_q != ST_IDLE);
		end else if (ce_i) begin
			if (wr_refused) begin
				err_q <= 1'b1;
			end else if (ctrl_wr) begin
				err_q <= wbyte[WR_ERR_BIT];
			end
		end
	end

	// ------------------------------------------------------------
	// Write sequencer.
	// ------------------------------------------------------------
	// The target is latched at start so a select write mid-cycle cannot redirect it.
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			st_q     <= ST_IDLE;
			wr_q     <= CTRL_RESET[WR_START_BIT];
			erase_q  <= 1'b0;
			write_q  <= 1'b0;
			target_q <= TGT_DATA;
		end else if (ce_i) begin
			unique case (st_q)
				ST_IDLE: begin
					if (wr_go) begin
						wr_q <= 1'b1;
						if (cfg_sel_q) begin
							target_q <= TGT_CONFIG;
						end else if (prog_sel_q) begin
							target_q <= TGT_PROG;
						end else begin
							target_q <= TGT_DATA;
						end
						if (erase_en_q) begin
							st_q    <= ST_ERASE;
							erase_q <= 1'b1;
						end else begin
							st_q    <= ST_WRITE;
							write_q <= 1'b1;
						end
					end
				end
				ST_ERASE, ST_WRITE: begin
					if (nvm_done_i) begin
						st_q    <= ST_IDLE;
						wr_q    <= 1'b0;
						erase_q <= 1'b0;
						write_q <= 1'b0;
					end
				end
				// An illegal state code returns to idle and drops the erase and write strobes.
				default: begin
					st_q    <= ST_IDLE;
					wr_q    <= 1'b0;
					erase_q <= 1'b0;
					write_q <= 1'b0;
				end
			endcase
		end
	end

	assign nvm_erase_o  = erase_q;
	assign nvm_write_o  = write_q;
	assign nvm_target_o = target_q;

	// ------------------------------------------------------------
	// Read launcher.
	// ------------------------------------------------------------
	// The read takes one cycle, so the start bit shows for exactly one cycle.
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			rd_q   <= CTRL_RESET[RD_START_BIT];
			read_q <= 1'b0;
		end else if (ce_i) begin
			rd_q   <= rd_go;
			read_q <= rd_go;
		end
	end

	assign nvm_read_o = read_q;

	// ------------------------------------------------------------
	// Interrupt status and mask.
	// ------------------------------------------------------------
	// Each source is a one-cycle condition, so the sticky register does the holding.
	always_comb begin
		ev_set               = EV_RESET;
		ev_set[EV_DONE_BIT]  = cycle_end;
		ev_set[EV_ERROR_BIT] = wr_refused;
		ev_set[EV_READ_BIT]  = rd_go;
	end

	// Writing one clears a flag; a new event in the same cycle wins.
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			ev_q <= EV_RESET;
		end else if (ce_i) begin
			if (wr_lane0 && (wb_adr_i == IRQ_ST_OFFSET)) begin
				ev_q <= (ev_q & ~wbyte[EV_COUNT-1:0]) | ev_set;
			end else begin
				ev_q <= ev_q | ev_set;
			end
		end
	end

	// Mask bits enable the matching status bits onto the interrupt line.
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			mask_q <= EV_RESET;
		end else if (ce_i && wr_lane0 && (wb_adr_i == IRQ_MK_OFFSET)) begin
			mask_q <= wbyte[EV_COUNT-1:0];
		end
	end

	// The interrupt is a plain level; software clears the status to drop it.
	assign irq_o = |(ev_q & mask_q);

	// ------------------------------------------------------------
	// Assertions.
	// ------------------------------------------------------------
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (srst_i);

	a_read_blocked_sel: assert property (
		(ce_i && ctrl_wr && wbyte[RD_START_BIT] && (prog_sel_q || cfg_sel_q))
		|=> !nvm_read_o)
		else $error("Read launched with a non-EEPROM select.");

	a_read_one_pulse: assert property (
		nvm_read_o && ce_i |=> !nvm_read_o && !rd_q)
		else $error("Read strobe or start bit held longer than one cycle.");

	a_no_permit_idle: assert property (
		(ce_i && st_q == ST_IDLE && !permit_q) |=> (st_q == ST_IDLE))
		else $error("Cycle started without write permit.");

	a_refused_sets_err: assert property (
		(ce_i && wr_refused) |=> err_q && ev_q[EV_ERROR_BIT])
		else $error("Refused write did not raise the error flag.");

	a_erase_chosen: assert property (
		(ce_i && wr_go && erase_en_q) |=> nvm_erase_o && !nvm_write_o && wr_q)
		else $error("Erase enable did not give an erase cycle.");

	a_write_chosen: assert property (
		(ce_i && wr_go && !erase_en_q) |=> nvm_write_o && !nvm_erase_o && wr_q)
		else $error("Plain write cycle not started.");

	a_done_clears_wr: assert property (
		(ce_i && cycle_end) |=> !wr_q && !nvm_write_o && !nvm_erase_o
			&& ev_q[EV_DONE_BIT])
		else $error("Write start bit not cleared on completion.");

	a_zero_keeps_wr: assert property (
		(ce_i && wr_q && ctrl_wr && !wbyte[WR_START_BIT] && !nvm_done_i) |=> wr_q)
		else $error("Software cleared the write start bit.");

	a_target_route: assert property (
		(ce_i && wr_go) |=> nvm_target_o == ($past(cfg_sel_q) ? TGT_CONFIG :
			$past(prog_sel_q) ? TGT_PROG : TGT_DATA))
		else $error("Cycle routed to the wrong memory.");

	a_sel_kept_err: assert property (
		(ce_i && wr_refused) |=> (prog_sel_q == $past(wbyte[PROG_SEL_BIT]))
			&& (cfg_sel_q == $past(wbyte[CFG_SEL_BIT])))
		else $error("Error path disturbed the memory select.");

	a_busy_holds: assert property (
		(ce_i && (st_q != ST_IDLE) && !nvm_done_i) |=> $stable(st_q) && wr_q)
		else $error("Cycle ended before the array reported completion.");

	a_target_held: assert property (
		((st_q != ST_IDLE) && !nvm_done_i) |=> $stable(nvm_target_o))
		else $error("Target changed while a cycle was running.");

	a_read_busy_blocked: assert property (
		(ce_i && ctrl_wr && wbyte[RD_START_BIT] && wr_q) |=> !nvm_read_o)
		else $error("Read launched while a write cycle was running.");

	a_one_strobe: assert property (
		!(nvm_erase_o && nvm_write_o))
		else $error("Erase and write strobes raised together.");

	// Clock enable, bus answer and status clearing.
	a_ack_one_cycle: assert property (
		(ce_i && wb_ack_o) |=> !wb_ack_o)
		else $error("Acknowledge held longer than one cycle.");

	a_freeze_hold: assert property (
		!ce_i |=> $stable(st_q) && $stable(wr_q) && $stable(err_q) && $stable(ev_q)
			&& $stable(wb_ack_o))
		else $error("State moved while the clock enable was low.");

	a_clear_done: assert property (
		(ce_i && wr_lane0 && (wb_adr_i == IRQ_ST_OFFSET) && wbyte[EV_DONE_BIT]
			&& !cycle_end) |=> !ev_q[EV_DONE_BIT])
		else $error("Writing one did not clear the done status.");

	c_erase_done: cover property (wr_go && erase_en_q ##[1:20] cycle_end);
	c_write_done: cover property (wr_go && !erase_en_q ##[1:20] cycle_end);
	c_refused:    cover property (wr_refused ##1 irq_o);
	c_read:       cover property (rd_go ##1 nvm_read_o);
	c_frozen:     cover property ((!ce_i && (st_q != ST_IDLE)) ##1 ce_i);

endmodule

// ===== tb/nvm_access_control_tb.sv
module nvm_access_control_tb
	import nvm_access_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------------------------------
	// Signals around the block.
	// ----------------------------------------------------------------
	logic        core_clk = 1'b0;  // Core clock, 40 ns period.
	logic        srst     = 1'b1;  // Synchronous reset, held at start.
	logic        cyc      = 1'b0;  // Bus cycle.
	logic        stb      = 1'b0;  // Bus strobe.
	logic        we       = 1'b0;  // Bus direction.
	logic [3:0]  adr      = 4'h0;  // Bus address.
	logic [31:0] wdat     = 32'h0; // Bus write data.
	logic [31:0] rdat;             // Bus read data.
	logic        ack;              // Bus acknowledge.
	logic        done     = 1'b0;  // Array completion, driven by hand.
	logic        ce       = 1'b1;  // Clock enable, dropped by the freeze scenario.
	logic        erase;            // Erase in progress.
	logic        write;            // Write in progress.
	logic        read;             // Read strobe.
	logic [1:0]  tgt;              // Addressed memory.
	logic        irq;              // Interrupt level.
	int          num_errors = 0;   // Mismatches seen.
	int          n_compared = 0;   // Comparisons made.
	int          n_reads    = 0;   // Read strobes seen at clock edges.
	logic [31:0] q;                // Last read value.
	logic [7:0]  ctl [3] = '{8'h04, 8'h94, 8'h44}; // Plain, erase, config.
	logic [1:0]  exp_tgt [3] = '{TGT_DATA, TGT_PROG, TGT_CONFIG};

	// The clock enable stays high except in the freeze scenario.
	nvm_access_control dut_u (
		.core_clk_i  (core_clk),
		.srst_i      (srst),
		.ce_i        (ce),
		.wb_cyc_i    (cyc),
		.wb_stb_i    (stb),
		.wb_we_i     (we),
		.wb_adr_i    (adr),
		.wb_sel_i    (4'hF),
		.wb_dat_i    (wdat),
		.wb_dat_o    (rdat),
		.wb_ack_o    (ack),
		.nvm_done_i  (done),
		.nvm_erase_o (erase),
		.nvm_write_o (write),
		.nvm_read_o  (read),
		.nvm_target_o(tgt),
		.irq_o       (irq)
	);

	// The clock toggles every half period.
	always #20 core_clk = ~core_clk;

	// Counts read strobes edge by edge, since a one-cycle pulse is over before a task returns.
	always @(posedge core_clk) begin
		if (read === 1'b1) begin
			n_reads++;
		end
	end

	// ----------------------------------------------------------------
	// Shared tasks.
	// ----------------------------------------------------------------
	// Counts a comparison and reports a mismatch at once.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD t=%0t %s got %0h exp %0h", $time, m, got, exp);
		end
	endtask

	// One classic cycle; held until ack is seen, so no cycle count is assumed.
	task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= {24'h0, d};
		do begin
			@(posedge core_clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		chk(ack, 1'b1, "no ack");
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask

	// Reports one completion from the array for a single cycle.
	task automatic finish_cycle();
		@(posedge core_clk);
		done <= 1'b1;
		@(posedge core_clk);
		done <= 1'b0;
		@(posedge core_clk);
		#1;
	endtask

	// ----------------------------------------------------------------
	// Scenarios.
	// ----------------------------------------------------------------
	// Plain write, erase and config write; a busy write with write start clear
	// and read start set must neither stop them nor launch a read.
	task automatic t_cycles();
		bus(1, IRQ_MK_OFFSET, 8'h07);
		foreach (ctl[i]) begin
			bus(1, CTRL_OFFSET, ctl[i]);
			bus(1, CTRL_OFFSET, ctl[i] | 8'h02);
			#1;
			chk(erase, ctl[i][4], "erase strobe");
			chk(write, !ctl[i][4], "write strobe");
			chk(tgt, exp_tgt[i], "target");
			bus(1, CTRL_OFFSET, ctl[i] | 8'h01);
			bus(0, CTRL_OFFSET, 8'h00);
			chk(q, ctl[i] | 8'h02, "start cleared by software");
			finish_cycle();
			chk(erase | write, 1'b0, "cycle end");
			bus(0, CTRL_OFFSET, 8'h00);
			chk(q, ctl[i], "start not self cleared");
			bus(0, IRQ_ST_OFFSET, 8'h00);
			chk(q, 32'h1, "done status");
			chk(irq, 1'b1, "irq on done");
			bus(1, IRQ_ST_OFFSET, 8'h01);
			#1;
			chk(irq, 1'b0, "irq after clear");
		end
		chk(n_reads, 0, "read while busy");
	endtask

	// Start without permit: nothing runs, error set, selects kept, mask works.
	task automatic t_refuse();
		bus(1, CTRL_OFFSET, 8'hC0);
		bus(1, CTRL_OFFSET, 8'hC2);
		@(posedge core_clk);
		#1;
		chk(erase | write, 1'b0, "refused start ran");
		bus(0, CTRL_OFFSET, 8'h00);
		chk(q, 32'hC8, "error or selects");
		bus(0, IRQ_ST_OFFSET, 8'h00);
		chk(q, 32'h2, "error status");
		chk(irq, 1'b1, "irq on error");
		bus(1, IRQ_MK_OFFSET, 8'h00);
		#1;
		chk(irq, 1'b0, "masked irq");
		bus(1, IRQ_ST_OFFSET, 8'h07);
		bus(1, IRQ_MK_OFFSET, 8'h07);
		bus(1, CTRL_OFFSET, 8'h00);
	endtask

	// Reads launch only with both selects clear and last one cycle.
	task automatic t_read();
		int base;
		base = n_reads;
		bus(1, CTRL_OFFSET, 8'h01);
		repeat (2) @(posedge core_clk);
		#1;
		chk(n_reads - base, 1, "read strobe count");
		chk(read, 1'b0, "read strobe length");
		bus(0, CTRL_OFFSET, 8'h00);
		chk(q, 32'h0, "read start not cleared");
		for (int s = 0; s < 2; s++) begin
			bus(1, CTRL_OFFSET, s ? 8'h40 : 8'h80);
			bus(1, CTRL_OFFSET, s ? 8'h41 : 8'h81);
			repeat (2) @(posedge core_clk);
			#1;
			chk(n_reads - base, 1, "read with select set");
			bus(0, CTRL_OFFSET, 8'h00);
			chk(q, s ? 32'h40 : 32'h80, "read start taken");
		end
		bus(1, IRQ_ST_OFFSET, 8'h07);
	endtask

	// A cycle frozen by the clock enable must ignore completion until it runs again.
	task automatic t_freeze();
		bus(1, CTRL_OFFSET, 8'h04);
		bus(1, CTRL_OFFSET, 8'h06);
		@(posedge core_clk);
		ce <= 1'b0;
		@(posedge core_clk);
		done <= 1'b1;
		@(posedge core_clk);
		done <= 1'b0;
		ce <= 1'b1;
		@(posedge core_clk);
		#1;
		chk(write, 1'b1, "write lost while frozen");
		finish_cycle();
		chk(write, 1'b0, "write after thaw");
		bus(1, IRQ_ST_OFFSET, 8'h07);
		bus(1, CTRL_OFFSET, 8'h00);
	endtask

	// A reset in mid-cycle stops the write and leaves the error flag set.
	task automatic t_reset_mid();
		bus(1, CTRL_OFFSET, 8'h04);
		bus(1, CTRL_OFFSET, 8'h06);
		@(posedge core_clk);
		srst <= 1'b1;
		repeat (2) @(posedge core_clk);
		srst <= 1'b0;
		#1;
		chk(write, 1'b0, "write after reset");
		bus(0, CTRL_OFFSET, 8'h00);
		chk(q, 32'h08, "error after reset");
	endtask

	// ----------------------------------------------------------------
	// Verdict and main sequence.
	// ----------------------------------------------------------------
	task automatic report_and_stop();
		$display("errors %0d compared %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// The error flag powers up unknown, so it is written before any check.
	initial begin
		repeat (16) @(posedge core_clk);
		srst <= 1'b0;
		bus(1, CTRL_OFFSET, 8'h00);
		bus(0, CTRL_OFFSET, 8'h00);
		chk(q, 32'h0, "control after reset");
		bus(1, 4'hC, 8'hFF);
		bus(0, 4'hC, 8'h00);
		chk(q, 32'h0, "unmapped read");
		t_cycles();
		t_refuse();
		t_read();
		t_freeze();
		t_reset_mid();
		report_and_stop();
	end

	// Whole run is a few hundred cycles; this limit is far beyond it.
	initial begin
		#200us;
		num_errors++;
		$display("BAD t=%0t watchdog expired", $time);
		report_and_stop();
	end
endmodule
